// ---- rtl/tael_pkg.sv ----
package tael_pkg;
   // ------------------------------------------------------------
   // Clock and sizing
   // ------------------------------------------------------------
   localparam int unsigned CLK_NS = 10; // 100 MHz period
   localparam int CNT_W = 23; // Deglitch counter width, fits 50 ms
   localparam int PULSE_W = 10; // One-shot pulse counter width
   localparam int SYNC_W = 11; // Synchronised input lanes
   localparam int DG_N = 5; // Deglitched events

   // Least time in ns to whole cycles, rounded up, at least one
   function automatic int unsigned cyc_min(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c == 0) ? 1 : c;
   endfunction

   // ------------------------------------------------------------
   // Times in ns
   // ------------------------------------------------------------
   localparam int unsigned CRIT_NS0 = 15000; // 15 us
   localparam int unsigned CRIT_NS1 = 100000; // 100 us
   localparam int unsigned CRIT_NS2 = 400000; // 400 us
   localparam int unsigned CRIT_NS3 = 800000; // 800 us
   localparam int unsigned NOM_NS0 = 1000000; // 1 ms
   localparam int unsigned NOM_NS1 = 50000000; // 50 ms
   localparam int unsigned DIS_NS0 = 1600000; // 1.6 ms
   localparam int unsigned DIS_NS1 = 100000; // 100 us
   localparam int unsigned DIS_NS2 = 6000000; // 6 ms
   localparam int unsigned DIS_NS3 = 12000000; // 12 ms
   localparam int unsigned RAIL_NS = 5000; // 5 us
   localparam int unsigned PULSE_NS = 10000; // One-shot alert width
   localparam int unsigned RAIL_CYC = cyc_min(RAIL_NS);
   localparam int unsigned PULSE_CYC = cyc_min(PULSE_NS);

   // ------------------------------------------------------------
   // Register byte addresses and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_OPT0_LO = 8'h36; // threshold options
   localparam logic [7:0] ADDR_OPT0_HI = 8'h37;
   localparam logic [7:0] ADDR_OPT1_LO = 8'h38; // event enables
   localparam logic [7:0] ADDR_OPT1_HI = 8'h39;
   localparam logic [15:0] OPT0_RST = 16'h4A65;
   localparam logic [15:0] OPT1_RST = 16'h81A0;

   // ------------------------------------------------------------
   // Field positions, threshold options
   // ------------------------------------------------------------
   localparam int F_RATIO_LSB = 11; // overload_limit_ratio [15:11]
   localparam int F_CRIT_LSB = 9; // critical_current_filter_time
   localparam int F_SAG_SEL = 8; // sag_trip_ratio_select
   localparam int F_DRAIN_LSB = 4; // rail_bus_drain_level [7:4]
   localparam int F_RALERT_LSB = 2; // rail_alert_level [3:2]
   localparam int F_NOM_DEG = 1; // nominal_overcurrent_filter_time
   localparam int F_SAG_LOW = 0; // sag_trip_lower_enable
   // Field positions, event enables
   localparam int F_DIS_LVL_LSB = 10; // discharge_overcurrent_level
   localparam int F_DIS_DEG_LSB = 8; // discharge filter time
   localparam int E_SAG = 7; // sag_event_enable
   localparam int E_COMP = 6; // comparator_event_enable
   localparam int E_CRIT = 5; // critical_current_event_enable
   localparam int E_NOM = 4; // nominal_overcurrent_event_enable
   localparam int E_DIS = 3; // discharge_event_enable
   localparam int E_RAIL = 2; // rail_alert_event_enable
   localparam int E_BAT = 1; // battery_removal_event_enable
   localparam int E_AC = 0; // adapter_removal_event_enable

   // ------------------------------------------------------------
   // Synchroniser lanes
   // ------------------------------------------------------------
   localparam int S_CRIT = 0;
   localparam int S_NOM = 1;
   localparam int S_DIS = 2;
   localparam int S_TH1 = 3;
   localparam int S_TH2 = 4;
   localparam int S_SAG = 5;
   localparam int S_COMP = 6;
   localparam int S_BAT = 7;
   localparam int S_AC = 8;
   localparam int S_HOLD = 9;
   localparam int S_ONE = 10;

   // ------------------------------------------------------------
   // Decoded values
   // ------------------------------------------------------------
   localparam logic [8:0] PCT_RST = 9'h096; // 150 %
   localparam logic [6:0] SAG_FULL = 7'h64; // 100 %
   localparam logic [6:0] SAG_90 = 7'h5A; // 90 %
   localparam logic [6:0] SAG_80 = 7'h50; // 80 %
   localparam int PCT_BASE = 105; // code 1 gives 110 %
   localparam int PCT_STEP = 5;
   localparam int PCT_HI_BASE = 250;
   localparam int PCT_HI_STEP = 50;
   localparam logic [4:0] RATIO_LO_MAX = 5'h19; // code 25
   localparam logic [4:0] RATIO_HI_MIN = 5'h1A; // code 26
   localparam logic [4:0] RATIO_HI_MAX = 5'h1E; // code 30
   localparam int MV_MULTI_BASE = 5900;
   localparam int MV_ONE_BASE = 3100;
   localparam int MV_STEP = 100;
   localparam logic [12:0] DRAIN_RST = 13'h1964; // 6500 mV
   localparam logic [12:0] RALERT_RST = 13'h1838; // 6200 mV
   localparam logic [15:0] DIS_RST = 16'h4000; // 16384 mA
   localparam int DIS_STEP_MA = 512;
endpackage

// ---- rtl/tael_deglitch.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Level deglitch: output rises after the input holds high
// for thr_in cycles, falls at once when the input drops
// ------------------------------------------------------------
module tael_deglitch
   import tael_pkg::*;
(
   input wire logic clock_in, // 100 MHz clock
   input wire logic rstn_in, // Synchronous reset, active low
   input wire logic level_in, // Synchronised raw condition
   input wire logic [CNT_W-1:0] thr_in, // Hold time in cycles
   output logic level_out // Filtered condition
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt; // Cycles seen high
      logic q; // Filtered level
   } tael_dg_t;

   tael_dg_t s_r, s_nxt; // State and next state

   // Next state
   always_comb
   begin
      s_nxt = s_r;
      if (!level_in)
      begin
         // Any low sample restarts the wait
         s_nxt.cnt = '0;
         s_nxt.q = 1'b0;
      end
      else if (!s_r.q)
      begin
         if (s_r.cnt >= thr_in - CNT_W'(1))
            s_nxt.q = 1'b1;
         else
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
   end

   // State register
   always_ff @(posedge clock_in)
   begin
      if (!rstn_in)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign level_out = s_r.q;

   // Output only rises after the full hold time
   a_filter_hold: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      $rose(s_r.q) |-> $past(s_r.cnt) >= $past(thr_in) - CNT_W'(1))
      else $error("deglitch rose before hold time");
   // Output drops one cycle after input falls
   a_filter_drop: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      !level_in |=> !s_r.q)
      else $error("deglitch held after input fell");
endmodule

// ---- rtl/tael_top.sv ----
`timescale 1ns/1ps
module tael_top
   import tael_pkg::*;
#(
   parameter int unsigned TIME_DIV = 1, // Shrinks critical, nominal and discharge filter times (not the rail filter), default 1, bench uses 500
   parameter int unsigned CRIT_CYC0 = cyc_min(CRIT_NS0 / TIME_DIV), // 15 us
   parameter int unsigned CRIT_CYC1 = cyc_min(CRIT_NS1 / TIME_DIV), // 100 us
   parameter int unsigned CRIT_CYC2 = cyc_min(CRIT_NS2 / TIME_DIV), // 400 us
   parameter int unsigned CRIT_CYC3 = cyc_min(CRIT_NS3 / TIME_DIV), // 800 us
   parameter int unsigned NOM_CYC0 = cyc_min(NOM_NS0 / TIME_DIV), // 1 ms
   parameter int unsigned NOM_CYC1 = cyc_min(NOM_NS1 / TIME_DIV), // 50 ms
   parameter int unsigned DIS_CYC0 = cyc_min(DIS_NS0 / TIME_DIV), // 1.6 ms
   parameter int unsigned DIS_CYC1 = cyc_min(DIS_NS1 / TIME_DIV), // 100 us
   parameter int unsigned DIS_CYC2 = cyc_min(DIS_NS2 / TIME_DIV), // 6 ms
   parameter int unsigned DIS_CYC3 = cyc_min(DIS_NS3 / TIME_DIV) // 12 ms
)(
   input wire logic clock_in, // 100 MHz clock
   input wire logic rstn_in, // Synchronous reset, active low
   input wire logic reg_wr_in, // Register byte write strobe
   input wire logic [7:0] reg_addr_in, // Register byte address
   input wire logic [7:0] reg_wdata_in, // Write byte
   output logic [7:0] reg_rdata_out, // Read byte, one cycle late
   input wire logic over_critical_in, // Above critical current
   input wire logic over_nominal_in, // Above nominal current
   input wire logic discharge_over_in, // Above discharge level
   input wire logic rail_below_drain_in, // Rail below drain level
   input wire logic rail_below_alert_in, // Rail below alert level
   input wire logic sag_in, // Bus below sag trip
   input wire logic comp_in, // Spare comparator trip
   input wire logic battery_present_in, // Battery present
   input wire logic adapter_present_in, // Adapter present
   input wire logic hold_up_mode_in, // Hold-up mode active
   input wire logic one_cell_in, // One-cell pack
   output logic throttle_alert_n_out, // Throttle alert, active low
   output logic [7:0] event_flags_out, // Enabled active events
   output logic bus_discharge_out, // Start bus discharge
   output logic [8:0] overload_pct_out, // Overload limit in percent
   output logic [6:0] sag_pct_out, // Sag trip in percent
   output logic [12:0] drain_mv_out, // Drain level in mV
   output logic [12:0] rail_alert_mv_out, // Alert level in mV
   output logic [15:0] discharge_ma_out // Discharge level in mA
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] opt0; // Threshold options
      logic [15:0] opt1; // Event enables
      logic [SYNC_W-1:0] s1; // First sync stage
      logic [SYNC_W-1:0] s2; // Second sync stage
      logic bat_prev; // Battery present, last cycle
      logic ac_prev; // Adapter present, last cycle
      logic hold_prev; // Hold-up, last cycle
      logic rail_prev; // Filtered rail alert, last cycle
      logic [PULSE_W-1:0] pcnt_bat; // One-shot timers
      logic [PULSE_W-1:0] pcnt_ac;
      logic [PULSE_W-1:0] pcnt_rail;
      logic [8:0] pct;
      logic [6:0] sag_pct;
      logic [12:0] drain_mv;
      logic [12:0] alert_mv;
      logic [15:0] dis_ma;
      logic [7:0] flags;
      logic alert_n;
      logic drain;
      logic [7:0] rdata;
   } tael_state_t;

   localparam tael_state_t ST_RST = '{opt0: OPT0_RST, opt1: OPT1_RST,
      pct: PCT_RST, sag_pct: SAG_80, drain_mv: DRAIN_RST,
      alert_mv: RALERT_RST, dis_ma: DIS_RST, alert_n: 1'b1,
      bat_prev: 1'b1, ac_prev: 1'b1, default: '0};

   tael_state_t s, n; // Registered and next state
   logic [DG_N-1:0] dg_q; // Filtered conditions
   logic [CNT_W-1:0] thr [DG_N]; // Hold times
   logic [7:0] ev; // Raw event vector

   // Byte address match, used for reads and writes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   // Rail alert level table
   function automatic logic [12:0] alert_mv(input logic [1:0] c,
                                            input logic one);
      logic [12:0] v;
      v = '0;
      case (c)
         2'h0: v = one ? 13'h0C1C : 13'h170C; // 3.1 / 5.9 V
         2'h1: v = one ? 13'h0CE4 : 13'h1838; // 3.3 / 6.2 V
         2'h2: v = one ? 13'h0DAC : 13'h1900; // 3.5 / 6.4 V
         default: v = one ? 13'h0E74 : 13'h1A90; // 3.7 / 6.8 V
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // Deglitch filters
   // ------------------------------------------------------------
   // Hold time selection per filtered event
   always_comb
   begin
      case (s.opt0[F_CRIT_LSB +: 2])
         2'h0: thr[0] = CNT_W'(CRIT_CYC0);
         2'h1: thr[0] = CNT_W'(CRIT_CYC1);
         2'h2: thr[0] = CNT_W'(CRIT_CYC2);
         default: thr[0] = CNT_W'(CRIT_CYC3);
      endcase
      thr[1] = s.opt0[F_NOM_DEG] ? CNT_W'(NOM_CYC1) : CNT_W'(NOM_CYC0);
      case (s.opt1[F_DIS_DEG_LSB +: 2])
         2'h0: thr[2] = CNT_W'(DIS_CYC0);
         2'h1: thr[2] = CNT_W'(DIS_CYC1);
         2'h2: thr[2] = CNT_W'(DIS_CYC2);
         default: thr[2] = CNT_W'(DIS_CYC3);
      endcase
      thr[3] = CNT_W'(RAIL_CYC);
      thr[4] = CNT_W'(RAIL_CYC);
   end

   // Lanes S_CRIT..S_TH2 line up with filter index
   generate
      for (genvar k = 0; k < DG_N; k++)
      begin : g_dg
         tael_deglitch u_dg (
            .clock_in(clock_in),
            .rstn_in(rstn_in),
            .level_in(s.s2[k]),
            .thr_in(thr[k]),
            .level_out(dg_q[k])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      n = s;
      // Pins cross into the clock domain through two stages
      n.s1 = {one_cell_in, hold_up_mode_in, adapter_present_in,
              battery_present_in, comp_in, sag_in, rail_below_alert_in,
              rail_below_drain_in, discharge_over_in, over_nominal_in,
              over_critical_in};
      n.s2 = s.s1;
      n.bat_prev = s.s2[S_BAT];
      n.ac_prev = s.s2[S_AC];
      n.hold_prev = s.s2[S_HOLD];
      n.rail_prev = dg_q[4];

      // Byte writes; host is expected to program both registers
      if (reg_wr_in)
      begin
         if (hit(reg_addr_in, ADDR_OPT0_LO))
            n.opt0[7:0] = reg_wdata_in;
         else if (hit(reg_addr_in, ADDR_OPT0_HI))
            n.opt0[15:8] = reg_wdata_in;
         else if (hit(reg_addr_in, ADDR_OPT1_LO))
            n.opt1[7:0] = reg_wdata_in;
         else if (hit(reg_addr_in, ADDR_OPT1_HI))
            n.opt1[15:8] = reg_wdata_in;
      end
      // hold-up entry sets enable, wins over a write
      if (s.s2[S_HOLD] && !s.hold_prev)
         n.opt1[E_RAIL] = 1'b1;

      // Read data, unmapped bytes read zero
      if (hit(reg_addr_in, ADDR_OPT0_LO))
         n.rdata = s.opt0[7:0];
      else if (hit(reg_addr_in, ADDR_OPT0_HI))
         n.rdata = s.opt0[15:8];
      else if (hit(reg_addr_in, ADDR_OPT1_LO))
         n.rdata = s.opt1[7:0];
      else if (hit(reg_addr_in, ADDR_OPT1_HI))
         n.rdata = s.opt1[15:8];
      else
         n.rdata = 8'h00;

      // low and high ratio bands, other codes hold
      if (s.opt0[F_RATIO_LSB +: 5] != 5'h00 &&
          s.opt0[F_RATIO_LSB +: 5] <= RATIO_LO_MAX)
         n.pct = 9'(PCT_BASE + PCT_STEP * int'(s.opt0[F_RATIO_LSB +: 5]));
      else if (s.opt0[F_RATIO_LSB +: 5] >= RATIO_HI_MIN &&
               s.opt0[F_RATIO_LSB +: 5] <= RATIO_HI_MAX)
         n.pct = 9'(PCT_HI_BASE + PCT_HI_STEP *
                    int'(s.opt0[F_RATIO_LSB +: 5] - RATIO_HI_MIN));
      if (!s.opt0[F_SAG_LOW])
         n.sag_pct = SAG_FULL;
      else
         n.sag_pct = s.opt0[F_SAG_SEL] ? SAG_90 : SAG_80;
      if (s.s2[S_ONE])
         n.drain_mv = 13'(MV_ONE_BASE + MV_STEP *
                          int'(s.opt0[F_DRAIN_LSB +: 3]));
      else
         n.drain_mv = 13'(MV_MULTI_BASE + MV_STEP *
                          int'(s.opt0[F_DRAIN_LSB +: 4]));
      n.alert_mv = alert_mv(s.opt0[F_RALERT_LSB +: 2], s.s2[S_ONE]);
      n.dis_ma = 16'(DIS_STEP_MA * int'(s.opt1[F_DIS_LVL_LSB +: 6]));

      n.drain = s.s2[S_HOLD] && dg_q[3];

      // One-shot timers count down to zero
      if (s.pcnt_bat != '0)
         n.pcnt_bat = s.pcnt_bat - PULSE_W'(1);
      if (s.pcnt_ac != '0)
         n.pcnt_ac = s.pcnt_ac - PULSE_W'(1);
      if (s.pcnt_rail != '0)
         n.pcnt_rail = s.pcnt_rail - PULSE_W'(1);
      if (s.bat_prev && !s.s2[S_BAT] && s.opt1[E_BAT])
         n.pcnt_bat = PULSE_W'(PULSE_CYC);
      if (s.ac_prev && !s.s2[S_AC] && s.opt1[E_AC])
         n.pcnt_ac = PULSE_W'(PULSE_CYC);
      // rail alert fires once per entry below level
      if (dg_q[4] && !s.rail_prev && s.opt1[E_RAIL])
         n.pcnt_rail = PULSE_W'(PULSE_CYC);

      // mask events by their enable bits
      n.flags = ev & s.opt1[7:0];
      // any enabled event pulls the alert low
      n.alert_n = ~|n.flags;
   end

   // Raw event vector, same bit order as the enables
   // sag event watches the bus comparator
   assign ev = {s.s2[S_SAG], s.s2[S_COMP], dg_q[0], dg_q[1], dg_q[2],
                s.pcnt_rail != '0, s.pcnt_bat != '0, s.pcnt_ac != '0};

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // reset loads default enables
   always_ff @(posedge clock_in)
   begin
      if (!rstn_in)
         s <= ST_RST;
      else
         s <= n;
   end

   // Outputs straight from the state flops
   assign reg_rdata_out = s.rdata;
   assign throttle_alert_n_out = s.alert_n;
   assign event_flags_out = s.flags;
   assign bus_discharge_out = s.drain;
   assign overload_pct_out = s.pct;
   assign sag_pct_out = s.sag_pct;
   assign drain_mv_out = s.drain_mv;
   assign rail_alert_mv_out = s.alert_mv;
   assign discharge_ma_out = s.dis_ma;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   sequence s_bat_fall;
      s.bat_prev && !s.s2[S_BAT] && s.opt1[E_BAT];
   endsequence
   sequence s_ac_fall;
      s.ac_prev && !s.s2[S_AC] && s.opt1[E_AC];
   endsequence

   a_mask_blocks_flag: assert property (
      1'b1 |=> (s.flags & ~$past(s.opt1[7:0])) == 8'h00)
      else $error("disabled event reached flags");
   a_alert_on_flag: assert property (
      (ev & s.opt1[7:0]) != 8'h00 |=> !throttle_alert_n_out)
      else $error("alert not pulled low");
   a_hold_sets_rail: assert property (
      $rose(s.s2[S_HOLD]) |=> s.opt1[E_RAIL])
      else $error("hold-up entry missed rail enable");
   a_bat_pulse_len: assert property (
      s_bat_fall |=> (s.pcnt_bat != '0)[*8])
      else $error("battery pulse too short");
   a_ac_pulse_len: assert property (
      s_ac_fall |=> (s.pcnt_ac != '0)[*8])
      else $error("adapter pulse too short");
   a_ratio_low_band: assert property (
      (s.opt0[15:11] != 5'h00 && s.opt0[15:11] <= RATIO_LO_MAX) |=>
      s.pct == 9'(PCT_BASE + PCT_STEP * int'($past(s.opt0[15:11]))))
      else $error("overload percent wrong");
   a_ratio_ignored: assert property (
      s.opt0[15:11] == 5'h1F |=> $stable(s.pct))
      else $error("ignored ratio code changed limit");
   a_sag_ratio: assert property (
      (s.opt0[F_SAG_LOW] && s.opt0[F_SAG_SEL]) |=> sag_pct_out == SAG_90)
      else $error("sag trip not 90 percent");
   a_drain_needs_hold: assert property (
      bus_discharge_out |-> $past(s.s2[S_HOLD]) && $past(dg_q[3]))
      else $error("bus drained outside hold-up");
   // Reset is the trigger here, so the default disable must not apply
   a_reset_enables: assert property (
      @(posedge clock_in) disable iff (1'b0)
      !rstn_in |=> s.opt1 == OPT1_RST)
      else $error("enables wrong after reset");
endmodule

// ---- tb/tael_host_model.sv ----
`timescale 1ns/1ps
// ------------------------------
// Host side of the register port
// ------------------------------
module tael_host_model
(
   input wire logic clock_in, // Bench clock
   output logic reg_wr_out, // Byte write strobe
   output logic [7:0] reg_addr_out, // Byte address
   output logic [7:0] reg_wdata_out, // Write byte
   input wire logic [7:0] reg_rdata_in // Read byte
);
   // Idle bus from time zero
   initial
   begin
      reg_wr_out = 1'b0;
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(negedge clock_in);
      reg_wr_out = 1'b0;
      // Stale byte inverted so it cannot pass by chance
      reg_wdata_out = ~d;
   endtask

   // read byte arrives one edge late
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock_in);
      reg_addr_out = a;
      @(negedge clock_in);
      d = reg_rdata_in;
   endtask
endmodule

// ---- tb/tb_throttle_alert_event_logic.sv ----
`timescale 1ns/1ps
module tb_throttle_alert_event_logic
   import tael_pkg::*;
;
   // Critical, nominal and discharge filter times scaled down by TDIV keep the run brief
   localparam int unsigned TDIV = 500;
   localparam int unsigned TQ = TDIV * CLK_NS; // ns per expected cycle
   int unsigned ct[4] = '{CRIT_NS0 / TQ, CRIT_NS1 / TQ, CRIT_NS2 / TQ,
      CRIT_NS3 / TQ};
   int unsigned nt[2] = '{NOM_NS0 / TQ, NOM_NS1 / TQ};
   int unsigned dt[4] = '{DIS_NS0 / TQ, DIS_NS1 / TQ, DIS_NS2 / TQ,
      DIS_NS3 / TQ};
   logic clk = 1'b0; // Bench clock
   logic rstn = 1'b0; // Reset, active low
   logic [10:0] ain = 11'h180; // Comparator lanes, both present
   logic wr; // Host strobe
   logic [7:0] addr, wdata, rdata; // Host bus
   logic alert_n, bus_dis; // Alert and drain
   logic [7:0] flags; // Event flags
   logic [8:0] pct; // Overload percent
   logic [6:0] sagp; // Sag percent
   logic [12:0] dmv, amv; // Rail levels
   logic [15:0] dma; // Discharge level
   logic [7:0] b; // Random byte
   logic s; // Random select
   int bad_count = 0;
   int cmp_count = 0;
   int p = 150; // Expected overload percent

   always #5 clk = ~clk;

   tael_host_model host (.clock_in(clk), .reg_wr_out(wr),
      .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));

   tael_top #(.TIME_DIV(TDIV)) uut (
      .clock_in(clk), .rstn_in(rstn), .reg_wr_in(wr),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .over_critical_in(ain[S_CRIT]), .over_nominal_in(ain[S_NOM]),
      .discharge_over_in(ain[S_DIS]), .rail_below_drain_in(ain[S_TH1]),
      .rail_below_alert_in(ain[S_TH2]), .sag_in(ain[S_SAG]),
      .comp_in(ain[S_COMP]), .battery_present_in(ain[S_BAT]),
      .adapter_present_in(ain[S_AC]), .hold_up_mode_in(ain[S_HOLD]),
      .one_cell_in(ain[S_ONE]), .throttle_alert_n_out(alert_n),
      .event_flags_out(flags), .bus_discharge_out(bus_dis),
      .overload_pct_out(pct), .sag_pct_out(sagp), .drain_mv_out(dmv),
      .rail_alert_mv_out(amv), .discharge_ma_out(dma));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      check(16'(d), 16'(e));
   endtask

   // Codes 0 and 31 leave the percent alone
   function automatic int pct_of(input logic [4:0] c, input int prev);
      if (c == 5'h00 || c == 5'h1F)
         return prev;
      return (c <= 5'h19) ? 105 + 5 * c : 250 + 50 * (c - 26);
   endfunction

   // Flag index 8 stands for the drain output
   function automatic logic obs(input int i);
      return (i == 8) ? bus_dis : flags[i];
   endfunction

   // Cycles from raising a lane to its flag, bounded
   task automatic latency(input int lane, input int i, input int thr);
      int n;
      n = 0;
      @(negedge clk);
      ain[lane] = 1'b1;
      while (obs(i) !== 1'b1 && n < thr + 20)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= thr + 20)
      begin
         bad_count++;
         print_verdict();
      end
      check(16'(n >= thr && n <= thr + 6), 16'h0001);
      ain[lane] = 1'b0;
      repeat (8) @(negedge clk);
   endtask

   // Width of the alert pulse after a lane change, zero if none
   task automatic oneshot(input int lane, input logic lvl, input logic en);
      int n, w;
      n = 0;
      w = 0;
      @(negedge clk);
      ain[lane] = lvl;
      while (alert_n !== 1'b0 && n < 700)
      begin
         @(negedge clk);
         n++;
      end
      while (alert_n === 1'b0 && w < 1200)
      begin
         @(negedge clk);
         w++;
      end
      check(16'(w), en ? 16'(PULSE_CYC) : 16'h0000);
   endtask

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial
   begin
      void'($urandom(32'hCC96765D));
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      check(16'(pct), 16'h0096);
      check(16'(sagp), 16'h0050);
      check(16'(dmv), 16'h1964);
      check(16'(amv), 16'h1838);
      check(dma, 16'h4000);
      check(16'(alert_n), 16'h0001);
      rdchk(8'h36, 8'h65);
      rdchk(8'h37, 8'h4A);
      rdchk(8'h38, 8'hA0);
      rdchk(8'h39, 8'h81);
      host.wr(8'h3A, 8'h5A);
      rdchk(8'h3A, 8'h00);
      latency(S_SAG, E_SAG, 0);
      ain[S_COMP] = 1'b1;
      repeat (10) @(negedge clk);
      check(16'(flags), 16'h0000);
      ain[S_COMP] = 1'b0;
      host.wr(8'h38, 8'hFF);
      for (int k = 0; k < 4; k++)
      begin
         host.wr(8'h37, 8'h48 | 8'(k << 1));
         latency(S_CRIT, E_CRIT, ct[k]);
         host.wr(8'h39, 8'h80 | 8'(k));
         latency(S_DIS, E_DIS, dt[k]);
      end
      for (int k = 0; k < 2; k++)
      begin
         host.wr(8'h36, 8'h65 | 8'(k << 1));
         latency(S_NOM, E_NOM, nt[k]);
      end
      ain[S_SAG] = 1'b1;
      ain[S_COMP] = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         b = 8'($urandom);
         host.wr(8'h38, b);
         repeat (6) @(negedge clk);
         check(16'(flags[7:6]), 16'(b[7:6]));
         check(16'(alert_n), 16'(~|b[7:6]));
      end
      ain[S_SAG] = 1'b0;
      ain[S_COMP] = 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         // Codes 31, 0 and 30 first, then random
         b[4:0] = (i < 2) ? 5'(31 * (1 - i))
            : (i == 2) ? 5'h1E : 5'($urandom_range(1, 30));
         host.wr(8'h37, {b[4:0], 3'b010});
         p = pct_of(b[4:0], p);
         repeat (3) @(negedge clk);
         check(16'(pct), 16'(p));
      end
      for (int i = 0; i < 8; i++)
      begin
         b = 8'($urandom);
         s = 1'($urandom);
         ain[S_ONE] = 1'($urandom);
         host.wr(8'h37, {7'h25, s});
         host.wr(8'h36, b);
         repeat (6) @(negedge clk);
         check(16'(sagp), b[0] ? (s ? 16'd90 : 16'd80) : 16'd100);
         check(16'(dmv), ain[S_ONE] ? 16'(3100 + 100 * b[6:4])
            : 16'(5900 + 100 * b[7:4]));
         check(16'(amv), 16'(ain[S_ONE] ? 3100 + 200 * b[3:2]
            : (b[3:2] == 2'd3) ? 6800 : 5900 + 300 * (b[3:2] != 0)
            + 200 * (b[3:2] == 2'd2)));
         b[5:0] = 6'($urandom_range(1, 63));
         host.wr(8'h39, {b[5:0], 2'b01});
         repeat (3) @(negedge clk);
         check(dma, 16'(b[5:0] * 512));
      end
      ain[S_ONE] = 1'b0;
      host.wr(8'h38, 8'h04);
      oneshot(S_TH2, 1'b1, 1'b1);
      ain[S_TH2] = 1'b0;
      host.wr(8'h38, 8'h00);
      ain[S_HOLD] = 1'b1;
      repeat (6) @(negedge clk);
      rdchk(8'h38, 8'h04);
      latency(S_TH1, 8, RAIL_CYC);
      ain[S_HOLD] = 1'b0;
      host.wr(8'h38, 8'h02);
      oneshot(S_BAT, 1'b0, 1'b1);
      ain[S_BAT] = 1'b1;
      host.wr(8'h38, 8'h00);
      oneshot(S_BAT, 1'b0, 1'b0);
      ain[S_BAT] = 1'b1;
      host.wr(8'h38, 8'h01);
      oneshot(S_AC, 1'b0, 1'b1);
      print_verdict();
   end
endmodule
